/* logic/asu_pkg.sv */
// Package for the arithmetic shift unit: constants, types and decoders.
package asu_pkg;

  localparam int unsigned ASU_W      = 16;
  localparam int unsigned ASU_RA_W   = 3;
  localparam int unsigned ASU_UPC_W  = 9;
  localparam int unsigned ASU_CNT_W  = 8;
  localparam int unsigned ASU_UW_W   = 24;
  localparam int unsigned ASU_DIR_BIT = 5;

  // Microword locations (octal 605, 607, 601, 17)
  localparam logic [8:0] ASU_UPC_SINGLE = 9'h185;
  localparam logic [8:0] ASU_UPC_PAIR   = 9'h187;
  localparam logic [8:0] ASU_UPC_MUL    = 9'h181;
  localparam logic [8:0] ASU_UPC_SVC    = 9'h00F;
  localparam logic [8:0] ASU_UPC_RST    = 9'h000;

  localparam logic [7:0]  ASU_CNT_RST  = 8'h00;
  localparam logic [15:0] ASU_WORD_RST = 16'h0000;
  localparam logic [23:0] ASU_UW_RST   = 24'h000000;
  localparam logic [2:0]  ASU_RA_RST   = 3'h0;

  typedef enum logic [1:0] {
    ASU_OP_SINGLE,
    ASU_OP_PAIR,
    ASU_OP_MUL
  } asu_op_e;

  typedef enum logic [1:0] {
    ASU_DIR_NONE,
    ASU_DIR_RIGHT,
    ASU_DIR_LEFT
  } asu_dir_e;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } asu_flags_s;

  localparam asu_flags_s ASU_FLAGS_RST = '0;

  typedef struct packed {
    asu_op_e     op;
    logic [2:0]  src;
    logic [15:0] operand;
  } asu_req_s;

  typedef struct packed {
    logic        we;
    logic [2:0]  addr;
    logic [15:0] data;
  } asu_wr_s;

  localparam asu_wr_s ASU_WR_RST = '0;

  // Shift direction from the count field
  function automatic asu_dir_e asu_dir_of(input logic [7:0] cnt);
    if (cnt[5:0] == 6'h00)
      return ASU_DIR_NONE;
    else if (cnt[ASU_DIR_BIT])
      return ASU_DIR_RIGHT;
    else
      return ASU_DIR_LEFT;
  endfunction

  // Partner register of a pair: register number with bit 0 forced
  function automatic logic [2:0] asu_odd_of(input logic [2:0] src);
    return {src[2:1], 1'b1};
  endfunction

endpackage

/* logic/asu_shift_step.sv */
// One shift pass of the 16-bit or 32-bit arithmetic shift.
`timescale 1ns/1ps
module asu_shift_step
  import asu_pkg::*;
(
  // Operands
  input  wire logic [15:0] br,
  input  wire logic [15:0] dr,
  // Mode
  input  wire logic        pair,
  input  wire logic        left,
  // Results
  output logic      [15:0] br_n,
  output logic      [15:0] dr_n,
  output logic             c_out,
  output logic             v_hit
);

  logic [16:0] sum;

  // Pair left carries the low half's top bit into the doubled high half
  assign sum = {1'b0, br} + {1'b0, br} + {16'h0000, pair & dr[15]};

  always_comb begin
    br_n  = br;
    dr_n  = dr;
    c_out = 1'b0;
    v_hit = 1'b0;
    if (left) begin
      br_n  = sum[15:0];
      c_out = br[15];
      v_hit = br[15] ^ br[14];
      if (pair)
        dr_n = {dr[14:0], 1'b0};
    end else begin
      br_n = {br[15], br[15:1]};
      if (pair) begin
        dr_n  = {br[0], dr[15:1]};
        c_out = dr[0];
      end else begin
        c_out = br[0];
      end
    end
  end

endmodule

/* logic/asu_zero_sign.sv */
// Sign and zero evaluation of a 16-bit or 32-bit result.
`timescale 1ns/1ps
module asu_zero_sign
  import asu_pkg::*;
(
  // Result halves
  input  wire logic [15:0] hi,
  input  wire logic [15:0] lo,
  input  wire logic        pair,
  // Flags
  output logic             neg,
  output logic             zero
);

  assign neg  = hi[15];
  // Pair zeroness ORs both halves, as the shared read bus does
  assign zero = pair ? ((hi | lo) == 16'h0000)
                     : (hi == 16'h0000);

endmodule

/* logic/asu_top.sv */
// Arithmetic shift unit: single and pair shift, multiply opening.
`timescale 1ns/1ps
module asu_top
  import asu_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Request from the host microsequencer
  input  wire logic        start,
  input  wire asu_req_s    req,
  // Host register file
  input  wire logic [15:0] rf_rdata,
  output logic      [2:0]  rf_raddr_q,
  output asu_wr_s          rf_wr_q,
  // Processor status
  output logic             ps_we_q,
  output asu_flags_s       ps_flags_q,
  // Microcode control
  output logic             sel_q,
  output logic      [8:0]  upc_q,
  output logic      [23:0] uword_q,
  output logic             svc_q,
  output logic             busy_q
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FETCH,
    ST_FETCH_HI,
    ST_ADJ,
    ST_LOOP,
    ST_WR_LO,
    ST_FLAGS,
    ST_MUL_LO,
    ST_MOVE,
    ST_NOP
  } asu_state_e;

  asu_state_e  state_q;
  asu_op_e     op_q;
  asu_dir_e    dir_q;
  logic [2:0]  src_q;
  logic [7:0]  cnt_q;
  logic [15:0] br_q;
  logic [15:0] dr_q;
  logic [15:0] mplier_q;
  asu_flags_s  loc_q;

  logic        pair;
  logic        left;
  logic        cnt_done;
  logic [15:0] br_n;
  logic [15:0] dr_n;
  logic        c_out;
  logic        v_hit;
  logic        res_neg;
  logic        res_zero;
  logic [31:0] product;
  logic        prod_wide;

  assign pair     = (op_q == ASU_OP_PAIR);
  assign left     = (dir_q == ASU_DIR_LEFT);
  assign cnt_done = (cnt_q[5:0] == 6'h00);
  // Sign-extended operands: the low 32 bits are the signed product
  assign product  = {{16{mplier_q[15]}}, mplier_q}
                    * {{16{rf_rdata[15]}}, rf_rdata};
  assign prod_wide = (product[31:16] != {16{product[15]}});

  asu_shift_step u_step (
    .br    (br_q),
    .dr    (dr_q),
    .pair  (pair),
    .left  (left),
    .br_n  (br_n),
    .dr_n  (dr_n),
    .c_out (c_out),
    .v_hit (v_hit)
  );

  asu_zero_sign u_zs (
    .hi   (br_q),
    .lo   (dr_q),
    .pair (pair),
    .neg  (res_neg),
    .zero (res_zero)
  );

  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start)
            state_q <= ST_FETCH;
        end
        ST_FETCH: begin
          if (op_q == ASU_OP_PAIR)
            state_q <= ST_FETCH_HI;
          else if (op_q == ASU_OP_MUL)
            state_q <= ST_MUL_LO;
          else if (dir_q == ASU_DIR_NONE)
            state_q <= ST_FLAGS;
          else
            state_q <= ST_ADJ;
        end
        ST_FETCH_HI: begin
          state_q <= (dir_q == ASU_DIR_NONE) ? ST_FLAGS : ST_ADJ;
        end
        ST_ADJ:    state_q <= ST_LOOP;
        ST_LOOP: begin
          // Exit decision lags one pass, as the one-word loop does
          if (cnt_done)
            state_q <= pair ? ST_WR_LO : ST_FLAGS;
        end
        ST_WR_LO:  state_q <= ST_FLAGS;
        ST_FLAGS:  state_q <= ST_MOVE;
        ST_MUL_LO: state_q <= ST_MOVE;
        ST_MOVE:   state_q <= ST_NOP;
        ST_NOP:    state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture and shift counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_q     <= ASU_OP_SINGLE;
      dir_q    <= ASU_DIR_NONE;
      src_q    <= ASU_RA_RST;
      cnt_q    <= ASU_CNT_RST;
      mplier_q <= ASU_WORD_RST;
    end else if (state_q == ST_IDLE && start) begin
      op_q     <= req.op;
      src_q    <= req.src;
      cnt_q    <= req.operand[7:0];
      dir_q    <= asu_dir_of(req.operand[7:0]);
      mplier_q <= req.operand;
    end else if (state_q == ST_FETCH && op_q == ASU_OP_MUL) begin
      mplier_q <= product[15:0];
    end else if ((state_q == ST_ADJ || state_q == ST_LOOP) && !cnt_done) begin
      // Two's complement field: counting up from it gives 64 minus field
      if (left)
        cnt_q <= cnt_q - 8'h01;
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end

  // Operand registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      br_q <= ASU_WORD_RST;
      dr_q <= ASU_WORD_RST;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start)
            br_q <= ASU_WORD_RST;
        end
        ST_FETCH: begin
          if (op_q == ASU_OP_PAIR)
            dr_q <= rf_rdata;
          else
            br_q <= rf_rdata;
        end
        ST_FETCH_HI: br_q <= rf_rdata;
        ST_LOOP: begin
          br_q <= br_n;
          dr_q <= dr_n;
        end
        default: begin
          br_q <= br_q;
          dr_q <= dr_q;
        end
      endcase
    end
  end

  // Register file access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rf_raddr_q <= ASU_RA_RST;
      rf_wr_q    <= ASU_WR_RST;
    end else begin
      rf_wr_q.we <= 1'b0;
      if (state_q == ST_IDLE && start) begin
        rf_raddr_q <= (req.op == ASU_OP_PAIR) ? asu_odd_of(req.src)
                                              : req.src;
      end
      if (state_q == ST_FETCH && pair)
        // An odd source names the same register twice
        rf_raddr_q <= src_q;
      if (state_q == ST_LOOP) begin
        rf_wr_q <= '{we: 1'b1, addr: src_q, data: br_n};
      end
      if (state_q == ST_FETCH && op_q == ASU_OP_MUL) begin
        rf_wr_q <= '{we: 1'b1, addr: src_q, data: product[31:16]};
      end
      if (state_q == ST_MUL_LO) begin
        rf_wr_q <= '{we: 1'b1, addr: asu_odd_of(src_q),
                     data: mplier_q};
      end
      if (state_q == ST_WR_LO) begin
        // Written after the high half, so an odd source keeps the low
        rf_wr_q <= '{we: 1'b1, addr: asu_odd_of(src_q),
                     data: dr_q};
      end
    end
  end

  // Local status flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      loc_q <= ASU_FLAGS_RST;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start && req.op == ASU_OP_PAIR)
            loc_q.v <= 1'b0;
        end
        ST_FETCH: begin
          if (op_q == ASU_OP_SINGLE)
            loc_q.v <= 1'b0;
          if (op_q == ASU_OP_MUL) begin
            loc_q.n <= product[31];
            loc_q.z <= (product == 32'h00000000);
            loc_q.v <= 1'b0;
            loc_q.c <= prod_wide;
          end
        end
        ST_LOOP: begin
          loc_q.c <= c_out;
          loc_q.v <= loc_q.v | (left & v_hit);
        end
        ST_FLAGS: begin
          loc_q.n <= res_neg;
          loc_q.z <= res_zero;
          if (dir_q == ASU_DIR_NONE) begin
            loc_q.v <= 1'b0;
            loc_q.c <= 1'b0;
          end
        end
        default: loc_q <= loc_q;
      endcase
    end
  end

  // Multiply holds the low product in the multiplier register until stored
  // (kept in mplier_q so the write step needs no second product)
  // Status hand-off and microcode control
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ps_we_q    <= 1'b0;
      ps_flags_q <= ASU_FLAGS_RST;
      sel_q      <= 1'b0;
      upc_q      <= ASU_UPC_RST;
      svc_q      <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      ps_we_q <= (state_q == ST_MOVE);
      svc_q   <= (state_q == ST_NOP);
      busy_q  <= (state_q != ST_IDLE) || start;
      if (state_q == ST_IDLE && start) begin
        sel_q <= 1'b1;
        unique case (req.op)
          ASU_OP_PAIR: upc_q <= ASU_UPC_PAIR;
          ASU_OP_MUL:  upc_q <= ASU_UPC_MUL;
          default:     upc_q <= ASU_UPC_SINGLE;
        endcase
      end
      if (state_q == ST_MOVE) begin
        ps_flags_q <= loc_q;
        sel_q      <= 1'b0;
      end
      if (state_q == ST_NOP)
        upc_q <= ASU_UPC_SVC;
    end
  end

  // Upper microword bits; cleared on the way out to avoid stale reentry
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      uword_q <= ASU_UW_RST;
    else if (state_q == ST_NOP)
      uword_q <= ASU_UW_RST;
    else if (state_q != ST_IDLE)
      uword_q <= {15'h0000, upc_q};
  end

  // Checking helpers: loop passes and the field that asked for them
  logic [6:0] pass_q;
  logic [5:0] field_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pass_q  <= 7'h00;
      field_q <= 6'h00;
    end else if (state_q == ST_IDLE && start) begin
      pass_q  <= 7'h00;
      field_q <= req.operand[5:0];
    end else if (state_q == ST_LOOP) begin
      pass_q <= pass_q + 7'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_entry_single: assert property (
    state_q == ST_IDLE && start && req.op == ASU_OP_SINGLE
    |=> upc_q == ASU_UPC_SINGLE && sel_q && br_q == 16'h0000
        && cnt_q == $past(req.operand[7:0]))
    else $error("single shift entry wrong");

  chk_entry_pair: assert property (
    state_q == ST_IDLE && start && req.op == ASU_OP_PAIR
    |=> upc_q == ASU_UPC_PAIR && !loc_q.v
        && rf_raddr_q == {$past(req.src[2:1]), 1'b1})
    else $error("pair shift entry wrong");

  chk_right_pass: assert property (
    state_q == ST_LOOP && !left && !pair
    |=> rf_wr_q.we && rf_wr_q.data == {$past(br_q[15]), $past(br_q[15:1])}
        && loc_q.c == $past(br_q[0]))
    else $error("right pass result wrong");

  chk_pair_right: assert property (
    state_q == ST_LOOP && !left && pair
    |=> dr_q == {$past(br_q[0]), $past(dr_q[15:1])}
        && loc_q.c == $past(dr_q[0]))
    else $error("pair right pass wrong");

  chk_left_ovf: assert property (
    state_q == ST_LOOP && left && br_q[15] != br_q[14]
    ##1 state_q == ST_LOOP |-> loc_q.v)
    else $error("left overflow not held");

  chk_loop_exit: assert property (
    state_q == ST_LOOP && cnt_done
    |=> state_q != ST_LOOP && cnt_q[5:0] == 6'h00)
    else $error("loop ran past zero count");

  chk_pass_count: assert property (
    state_q == ST_LOOP && cnt_done
    |=> pass_q == (left ? {1'b0, field_q} : 7'h40 - {1'b0, field_q}))
    else $error("pass count differs from count field");

  chk_zero_count: assert property (
    state_q == ST_FLAGS && dir_q == ASU_DIR_NONE
    |=> !loc_q.v && !loc_q.c && loc_q.n == $past(br_q[15]))
    else $error("zero count flags wrong");

  chk_move_ps: assert property (
    state_q == ST_MOVE
    |=> ps_we_q && !sel_q && ps_flags_q == $past(loc_q))
    else $error("status hand-off wrong");

  chk_exit_clean: assert property (
    state_q == ST_NOP
    |=> uword_q == 24'h000000 && svc_q && upc_q == ASU_UPC_SVC)
    else $error("exit word not clean");

  cov_right: cover property (
    state_q == ST_LOOP && !left ##1 state_q == ST_FLAGS);
  cov_pair_left: cover property (state_q == ST_LOOP && left && pair);
  cov_none: cover property (state_q == ST_FLAGS && dir_q == ASU_DIR_NONE);
  cov_mul: cover property (state_q == ST_MUL_LO);

endmodule

/* dv/asu_rf_model.sv */
// Host register file and service resume point facing the shift unit.
`timescale 1ns/1ps
module asu_rf_model
  import asu_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Register file access
  input  wire logic [2:0]  raddr,
  input  wire asu_wr_s     wr,
  output logic      [15:0] rdata,
  // Exit from the option
  input  wire logic        svc,
  input  wire logic [8:0]  upc
);
  logic [15:0] regs [8];
  int          n_resume;

  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    n_resume = 0;
  end

  // Combinational read: the unit samples the cycle after the address moves
  assign rdata = regs[raddr];

  always @(posedge ref_clk) begin
    if (wr.we) begin
      regs[wr.addr] <= wr.data;
    end
  end

  // Host goes back to its service word after each exit
  always @(posedge ref_clk) begin
    if (svc && upc == ASU_UPC_SVC) begin
      n_resume <= n_resume + 1;
    end
  end
endmodule

/* dv/asu_top_tb.sv */
// Self-checking testbench for the arithmetic shift unit.
`timescale 1ns/1ps
module asu_top_tb
  import asu_pkg::*;
();
  logic        ref_clk;
  logic        sys_rst;
  logic        start;
  asu_req_s    req;
  logic [15:0] rf_rdata;
  logic [2:0]  rf_raddr_q;
  asu_wr_s     rf_wr_q;
  logic        ps_we_q;
  asu_flags_s  ps_flags_q;
  logic        sel_q;
  logic [8:0]  upc_q;
  logic [23:0] uword_q;
  logic        svc_q;
  logic        busy_q;
  int          n_fail;
  int          n_tests;
  int          n_wr;
  int          n_we;
  int          n_runs;
  asu_flags_s  psf;
  logic        we_sel;

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  asu_top DUT (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .start      (start),
    .req        (req),
    .rf_rdata   (rf_rdata),
    .rf_raddr_q (rf_raddr_q),
    .rf_wr_q    (rf_wr_q),
    .ps_we_q    (ps_we_q),
    .ps_flags_q (ps_flags_q),
    .sel_q      (sel_q),
    .upc_q      (upc_q),
    .uword_q    (uword_q),
    .svc_q      (svc_q),
    .busy_q     (busy_q)
  );

  asu_rf_model RF (
    .ref_clk (ref_clk),
    .raddr   (rf_raddr_q),
    .wr      (rf_wr_q),
    .rdata   (rf_rdata),
    .svc     (svc_q),
    .upc     (upc_q)
  );

  // Registered outputs are settled at the falling edge
  always @(negedge ref_clk) begin
    if (rf_wr_q.we === 1'b1) n_wr++;
    if (ps_we_q === 1'b1) begin
      n_we++;
      psf = ps_flags_q;
      we_sel = sel_q;
    end
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Reference result: x holds high half over low half
  function automatic void ref_op(input asu_op_e op,
      input logic [15:0] a, b, cnt,
      output logic [31:0] x, output asu_flags_s f);
    logic signed [31:0] p;
    logic               v;
    logic               c;
    int                 m;
    v = 1'b0;
    c = 1'b0;
    x = (op == ASU_OP_SINGLE) ? {a, 16'h0000} : {a, b};
    m = cnt[5] ? 64 - int'(cnt[5:0]) : int'(cnt[5:0]);
    if (op == ASU_OP_MUL) begin
      p = $signed(a) * $signed(cnt);
      x = p;
      c = !((&p[31:15]) || !(|p[31:15]));
    end else begin
      for (int k = 0; k < m; k++) begin
        if (cnt[5]) begin
          c = (op == ASU_OP_PAIR) ? x[0] : x[16];
          x = {x[31], x[31:1]};
        end else begin
          v = v | (x[31] ^ x[30]);
          c = x[31];
          x = x << 1;
        end
      end
    end
    f.n = x[31];
    f.z = (op == ASU_OP_SINGLE) ? (x[31:16] == 16'h0000) : (x == 0);
    f.v = v;
    f.c = c;
  endfunction

  task automatic run(input asu_op_e op, input logic [2:0] src,
      input logic [15:0] cnt, a, b, input bit poke);
    logic [2:0]  od;
    logic [31:0] x;
    asu_flags_s  ef;
    logic [8:0]  ent;
    int          n;
    int          m;
    od = {src[2:1], 1'b1};
    ent = (op == ASU_OP_SINGLE) ? ASU_UPC_SINGLE :
          (op == ASU_OP_PAIR) ? ASU_UPC_PAIR : ASU_UPC_MUL;
    m = cnt[5] ? 64 - int'(cnt[5:0]) : int'(cnt[5:0]);
    ref_op(op, a, b, cnt, x, ef);
    @(negedge ref_clk);
    RF.regs[src] = a;
    if (op == ASU_OP_PAIR && od != src) RF.regs[od] = b;
    n_wr = 0;
    n_we = 0;
    n_runs++;
    start = 1'b1;
    req = '{op: op, src: src, operand: cnt};
    @(negedge ref_clk);
    start = 1'b0;
    chk({busy_q, sel_q, upc_q}, {2'b11, ent}, "entry word");
    if (poke) begin
      // A second request while busy must leave the operation untouched
      @(negedge ref_clk);
      start = 1'b1;
      req = '{op: ASU_OP_MUL, src: 3'h0, operand: 16'h0003};
      @(negedge ref_clk);
      start = 1'b0;
    end
    for (n = 0; n < 400 && svc_q !== 1'b1; n++) @(negedge ref_clk);
    if (n >= 400) begin
      n_fail++;
      $display("[FAIL] %0t no exit from the option", $time);
      close_out;
    end
    chk({sel_q, upc_q, uword_q}, {1'b0, ASU_UPC_SVC, ASU_UW_RST},
        "exit word");
    chk(psf, ef, "status flags");
    chk({we_sel, n_we[1:0]}, 3'b001, "status load");
    if (op == ASU_OP_SINGLE) begin
      chk(RF.regs[src], x[31:16], "result");
    end else begin
      chk(RF.regs[od], x[15:0], "low result");
      if (od != src) chk(RF.regs[src], x[31:16], "high");
    end
    if (op != ASU_OP_MUL && cnt[5:0] != 6'h00)
      chk(n_wr, m + (op == ASU_OP_PAIR), "passes");
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    n_runs = 0;
    n_wr = 0;
    n_we = 0;
    psf = '0;
    we_sel = 1'b0;
    sys_rst = 1'b1;
    start = 1'b0;
    req = '0;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    run(ASU_OP_SINGLE, 3'h1, 16'h0000, 16'h0000, 16'h0, 0);
    run(ASU_OP_SINGLE, 3'h2, 16'h0040, 16'h8001, 16'h0, 1);
    run(ASU_OP_SINGLE, 3'h3, 16'h003F, 16'h8001, 16'h0, 0);
    run(ASU_OP_SINGLE, 3'h4, 16'h0020, 16'h8000, 16'h0, 0);
    run(ASU_OP_SINGLE, 3'h5, 16'hFF21, 16'h4000, 16'h0, 1);
    run(ASU_OP_SINGLE, 3'h6, 16'h0001, 16'h4000, 16'h0, 0);
    run(ASU_OP_SINGLE, 3'h7, 16'h001F, 16'h0001, 16'h0, 0);
    run(ASU_OP_SINGLE, 3'h0, 16'h0002, 16'hC000, 16'h0, 0);
    run(ASU_OP_PAIR, 3'h2, 16'h0000, 16'h0000, 16'h0000, 0);
    run(ASU_OP_PAIR, 3'h2, 16'h0000, 16'h0000, 16'h0001, 0);
    run(ASU_OP_PAIR, 3'h4, 16'h003F, 16'h0001, 16'h0000, 0);
    run(ASU_OP_PAIR, 3'h2, 16'h0030, 16'h8000, 16'h0001, 1);
    run(ASU_OP_PAIR, 3'h4, 16'h0001, 16'h4000, 16'h8000, 0);
    run(ASU_OP_PAIR, 3'h6, 16'h0011, 16'h0001, 16'h0003, 0);
    run(ASU_OP_PAIR, 3'h3, 16'h0001, 16'h1234, 16'h1234, 0);
    run(ASU_OP_PAIR, 3'h5, 16'h003E, 16'h8765, 16'h8765, 0);
    run(ASU_OP_MUL, 3'h2, 16'hFFFB, 16'h0003, 16'h0, 0);
    run(ASU_OP_MUL, 3'h4, 16'h8000, 16'h8000, 16'h0, 0);
    run(ASU_OP_MUL, 3'h6, 16'h0000, 16'h1234, 16'h0, 0);
    run(ASU_OP_MUL, 3'h1, 16'h0002, 16'h7FFF, 16'h0, 0);
    @(negedge ref_clk);
    chk(RF.n_resume, n_runs, "resume count");
    close_out;
  end
endmodule
